// ===== inc/adc_seq_pkg.sv
/*
  shared constants for the converter sequencer: register indices,
  field positions, reset values, timing counts and the state encoding.
  assumes a 100 MHz system clock and a Wishbone word-addressed map.
*/
`default_nettype none

package adc_seq_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_WIDTH = 10;
  localparam int unsigned CHANNEL_COUNT = 9;
  localparam int unsigned COUNT_WIDTH = 9;

  // ----------------------------------------------------------------
  // register word indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_CONTROL_STATUS = 3'h0;
  localparam logic [2:0] IDX_RESULT_HIGH = 3'h1;
  localparam logic [2:0] IDX_POWER = 3'h2;
  localparam logic [2:0] IDX_IRQ_STATUS = 3'h3;
  localparam logic [2:0] IDX_IRQ_MASK = 3'h4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CS_DONE_BIT = 7;
  localparam int unsigned CS_COMPARE_BIT = 6;
  localparam int unsigned CS_SAMPLE_TIME_SELECT_LSB = 4;
  localparam int unsigned CS_CHANNEL_LSB = 0;
  localparam int unsigned CS_RESULT_LSB = 0;
  localparam int unsigned PWR_ENABLE_BIT = 0;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_COMPARE_BIT = 1;

  // ----------------------------------------------------------------
  // reset values and the first trial code
  // ----------------------------------------------------------------
  localparam logic [3:0] CHANNEL_RESET = 4'h0;
  localparam logic [1:0] SAMPLE_TIME_SELECT_RESET = 2'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] TRIAL_FIRST = 10'h200;

  // ----------------------------------------------------------------
  // timing, in oscillator periods unless marked
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned OSC_PERIOD_NS = 100;
  localparam int unsigned OSC_DIV_DEFAULT = OSC_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam logic [8:0] SAMPLE_OSC_0 = 9'h014;
  localparam logic [8:0] SAMPLE_OSC_1 = 9'h03C;
  localparam logic [8:0] SAMPLE_OSC_2 = 9'h08C;
  localparam logic [8:0] SAMPLE_OSC_3 = 9'h12C;
  localparam logic [8:0] SAR_OSC = 9'h014;
  localparam logic [8:0] WARMUP_OSC = 9'h014;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_WARMUP = 5'b00010,
    ST_IDLE = 5'b00100,
    ST_SAMPLE = 5'b01000,
    ST_CONVERT = 5'b10000
  } seq_state_t;

endpackage

`default_nettype wire

// ===== hdl/sync_2ff.sv
/*
  two flip-flop synchroniser for a bundle of independent levels.
  assumes each bit is a slow level; no bundle coherence is promised.
*/
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_t;

  sync_t state_reg;
  sync_t state_next;

  // first stage feeds only the second stage
  always_comb begin
    state_next.first = async_in;
    state_next.second = state_reg.first;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.second;

endmodule // sync_2ff

`default_nettype wire

// ===== hdl/osc_tick_divider.sv
/*
  divides the system clock into a one-cycle oscillator-period enable.
  assumes a single clock domain; the tick runs whenever enable is high.
*/
`timescale 1ns/1ps
`default_nettype none

module osc_tick_divider #(
  parameter int unsigned DIV = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // control
  input wire logic enable,
  output logic tick
);

  // a zero divide has no last count to wrap at
  if (DIV < 1) begin : g_bad_div
    $error("DIV must be at least 1");
  end

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } div_t;

  div_t state_reg;
  div_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!enable) begin
      state_next.count = '0;
    end else if (state_reg.count == LAST) begin
      state_next.count = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + CW'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule // osc_tick_divider

`default_nettype wire

// ===== hdl/sar_adc_sequencer.sv
/*
  sequencer for a 10-bit successive approximation converter with a
  nine-way input multiplexer and a half-supply comparator flag.
  assumes an analog front end that samples while sampleHold is high,
  compares its held input against dacCode, and a comparator that
  reports the comparator pin below half supply; both arrive async.
*/
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer #(
  parameter int unsigned OSC_DIV = adc_seq_pkg::OSC_DIV_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [4:2] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // analog front end
  input wire logic sarCompare,
  input wire logic halfSupplyBelow,
  output logic converterPowerOn,
  output logic sampleHold,
  output logic [8:0] channelSelect,
  output logic [9:0] dacCode,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // the synchronised comparator lags two cycles; a trial must settle
  // within one oscillator period, so the divider cannot be shorter
  if (OSC_DIV < 4) begin : g_bad_div
    $error("OSC_DIV must be at least 4");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    adc_seq_pkg::seq_state_t state;
    logic power;
    logic done;
    logic [3:0] channel;
    logic [1:0] sample_time_select;
    logic [9:0] result;
    logic [9:0] trial;
    logic [8:0] count;
    logic [8:0] chanSel;
    logic sampling;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } seq_t;

  seq_t state_reg;
  seq_t state_next;

  logic oscTick;
  logic sarCmpSync;
  logic belowSync;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // oscillator tick comes from the system clock, so processor
  // speed modes that slow that clock also stretch a conversion
  osc_tick_divider #(
    .DIV(OSC_DIV)
  ) u_div (
    .clock(clock),
    .arst_n(arst_n),
    .enable(state_reg.power),
    .tick(oscTick)
  );

  sync_2ff #(
    .WIDTH(2)
  ) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .async_in({sarCompare, halfSupplyBelow}),
    .sync_out({sarCmpSync, belowSync})
  );

  function automatic logic [8:0] sample_len(input logic [1:0] sel);
    case (sel)
      2'h0: sample_len = adc_seq_pkg::SAMPLE_OSC_0;
      2'h1: sample_len = adc_seq_pkg::SAMPLE_OSC_1;
      2'h2: sample_len = adc_seq_pkg::SAMPLE_OSC_2;
      default: sample_len = adc_seq_pkg::SAMPLE_OSC_3;
    endcase
  endfunction

  function automatic logic [8:0] chan_decode(input logic [3:0] ch);
    logic [8:0] sel;
    sel = 9'h000;
    if (ch >= 4'h1 && ch <= 4'h9) begin
      sel[ch - 4'h1] = 1'b1;
    end
    chan_decode = sel;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic accept;
  logic wrEn;
  logic doneEvent;
  logic cmpEvent;
  logic [9:0] t;
  logic [3:0] idx;
  logic [1:0] clr;
  logic [7:0] csRead;

  always_comb begin
    state_next = state_reg;
    t = state_reg.trial;
    idx = 4'h0;
    clr = 2'h0;
    doneEvent = 1'b0;
    cmpEvent = 1'b0;
    csRead = 8'h00;

    // the edge at which ack is high is the one the master samples
    accept = wbCyc & wbStb & state_reg.ack;
    wrEn = accept & wbWe & wbSel[0];
    state_next.ack = wbCyc & wbStb & ~state_reg.ack;

    case (state_reg.state)
      adc_seq_pkg::ST_OFF: begin
        if (state_reg.power) begin
          state_next.state = adc_seq_pkg::ST_WARMUP;
          state_next.count = 9'h000;
        end
      end
      adc_seq_pkg::ST_WARMUP: begin
        if (oscTick) begin
          if (state_reg.count == adc_seq_pkg::WARMUP_OSC - 9'h001) begin
            state_next.state = adc_seq_pkg::ST_IDLE;
            state_next.done = 1'b1;
          end else begin
            state_next.count = state_reg.count + 9'h001;
          end
        end
      end
      adc_seq_pkg::ST_IDLE: begin
        state_next.sampling = 1'b0;
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (oscTick) begin
          if (state_reg.count == sample_len(state_reg.sample_time_select) - 9'h001) begin
            state_next.state = adc_seq_pkg::ST_CONVERT;
            state_next.count = 9'h000;
            state_next.sampling = 1'b0;
            state_next.trial = adc_seq_pkg::TRIAL_FIRST;
          end else begin
            state_next.count = state_reg.count + 9'h001;
          end
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        // two periods per bit: set the trial, then keep or drop it
        if (oscTick) begin
          if (state_reg.count[0]) begin
            idx = 4'h9 - 4'(state_reg.count[4:1]);
            t[idx] = sarCmpSync;
            if (idx != 4'h0) begin
              t[idx - 4'h1] = 1'b1;
            end
            state_next.trial = t;
          end
          if (state_reg.count == adc_seq_pkg::SAR_OSC - 9'h001) begin
            state_next.state = adc_seq_pkg::ST_IDLE;
            state_next.result = t;
            state_next.done = 1'b1;
            doneEvent = 1'b1;
          end else begin
            state_next.count = state_reg.count + 9'h001;
          end
        end
      end
      default: begin
        state_next.state = adc_seq_pkg::ST_OFF;
      end
    endcase

    // comparator event is gated by the period tick, so a low pin
    // keeps raising it every period rather than once
    cmpEvent = oscTick & belowSync;

    // powering down aborts whatever runs
    if (!state_reg.power) begin
      state_next.state = adc_seq_pkg::ST_OFF;
      state_next.done = 1'b0;
      state_next.sampling = 1'b0;
    end

    // register writes
    if (wrEn) begin
      case (wbAdr)
        adc_seq_pkg::IDX_CONTROL_STATUS: begin
          state_next.channel =
            wbDatIn[adc_seq_pkg::CS_CHANNEL_LSB +: 4];
          state_next.sample_time_select = wbDatIn[adc_seq_pkg::CS_SAMPLE_TIME_SELECT_LSB +: 2];
          state_next.done = 1'b0;
          if (state_reg.power) begin
            // old result stays readable; busy shows through done
            state_next.state = adc_seq_pkg::ST_SAMPLE;
            state_next.count = 9'h000;
            state_next.sampling = 1'b1;
          end
        end
        adc_seq_pkg::IDX_POWER: begin
          state_next.power = wbDatIn[adc_seq_pkg::PWR_ENABLE_BIT];
        end
        adc_seq_pkg::IDX_IRQ_STATUS: begin
          clr = wbDatIn[1:0];
        end
        adc_seq_pkg::IDX_IRQ_MASK: begin
          state_next.irqMask = wbDatIn[1:0];
        end
        default: begin
          state_next.irqMask = state_reg.irqMask;
        end
      endcase
    end

    // set wins over the clear written in the same cycle
    state_next.irqStatus = (state_reg.irqStatus & ~clr);
    state_next.irqStatus[adc_seq_pkg::IRQ_DONE_BIT] =
      state_next.irqStatus[adc_seq_pkg::IRQ_DONE_BIT] | doneEvent;
    state_next.irqStatus[adc_seq_pkg::IRQ_COMPARE_BIT] =
      state_next.irqStatus[adc_seq_pkg::IRQ_COMPARE_BIT] | cmpEvent;
    state_next.irq = |(state_reg.irqStatus & state_reg.irqMask);

    // multiplexer only while powered
    state_next.chanSel = state_next.power ?
      chan_decode(state_next.channel) : 9'h000;

    // read data, captured with the ack
    csRead[adc_seq_pkg::CS_DONE_BIT] = state_reg.done;
    csRead[adc_seq_pkg::CS_COMPARE_BIT] = belowSync;
    csRead[adc_seq_pkg::CS_SAMPLE_TIME_SELECT_LSB +: 2] = state_reg.sample_time_select;
    csRead[adc_seq_pkg::CS_RESULT_LSB +: 2] =
      state_reg.result[1:0];
    state_next.rdata = 32'h0000_0000;
    if (wbCyc && wbStb && !state_reg.ack && !wbWe) begin
      case (wbAdr)
        adc_seq_pkg::IDX_CONTROL_STATUS: begin
          state_next.rdata = {24'h00_0000, csRead};
        end
        adc_seq_pkg::IDX_RESULT_HIGH: begin
          state_next.rdata = {24'h00_0000, state_reg.result[9:2]};
        end
        adc_seq_pkg::IDX_POWER: begin
          state_next.rdata = {31'h0000_0000, state_reg.power};
        end
        adc_seq_pkg::IDX_IRQ_STATUS: begin
          state_next.rdata = {30'h0000_0000, state_reg.irqStatus};
        end
        adc_seq_pkg::IDX_IRQ_MASK: begin
          state_next.rdata = {30'h0000_0000, state_reg.irqMask};
        end
        default: begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.state <= adc_seq_pkg::ST_OFF;
      state_reg.power <= 1'b0;
      state_reg.done <= 1'b0;
      state_reg.channel <= adc_seq_pkg::CHANNEL_RESET;
      state_reg.sample_time_select <= adc_seq_pkg::SAMPLE_TIME_SELECT_RESET;
      state_reg.result <= adc_seq_pkg::RESULT_RESET;
      state_reg.trial <= adc_seq_pkg::RESULT_RESET;
      state_reg.count <= 9'h000;
      state_reg.chanSel <= 9'h000;
      state_reg.sampling <= 1'b0;
      state_reg.irqStatus <= 2'h0;
      state_reg.irqMask <= 2'h0;
      state_reg.irq <= 1'b0;
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wbDatOut = state_reg.rdata;
  assign wbAck = state_reg.ack;
  assign converterPowerOn = state_reg.power;
  assign sampleHold = state_reg.sampling;
  assign channelSelect = state_reg.chanSel;
  assign dacCode = state_reg.trial;
  assign irq = state_reg.irq;

endmodule // sar_adc_sequencer

`default_nettype wire

// ===== verification/analog_front_model.sv
/*
  behavioural analog front end: nine pin levels held as ideal codes,
  a sample-and-hold and the trial comparator of the converter.
  assumes the bench sets the pin codes; an open input drifts.
*/
`timescale 1ns/1ps
`default_nettype none

module analog_front_model (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // pin levels, pin k+1 in bits 10k+9..10k
  input wire logic [89:0] pinLevels,
  // sequencer side
  input wire logic sampleHold,
  input wire logic [8:0] channelSelect,
  input wire logic [9:0] dacCode,
  output logic sarCompare
);
  logic [9:0] heldCode;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      heldCode <= 10'h2C5;
    end else if (sampleHold) begin
      // an open input keeps changing, so a stale code cannot pass
      if (channelSelect == 9'h000) begin
        heldCode <= ~heldCode;
      end
      for (int k = 0; k < 9; k++) begin
        if (channelSelect[k]) begin
          heldCode <= pinLevels[k*10 +: 10];
        end
      end
    end
  end

  // ideal quantiser: pin code equals the truncated voltage ratio
  assign sarCompare = (heldCode >= dacCode);
endmodule // analog_front_model

`default_nettype wire

// ===== verification/sar_adc_sequencer_props.sv
/*
  port checker for the converter sequencer.
  assumes it is bound onto every sar_adc_sequencer instance.
*/
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer_props #(
  parameter int unsigned OSC_DIV = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [4:2] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  input wire logic [31:0] wbDatOut,
  input wire logic wbAck,
  // analog side
  input wire logic sarCompare,
  input wire logic halfSupplyBelow,
  input wire logic converterPowerOn,
  input wire logic sampleHold,
  input wire logic [8:0] channelSelect,
  input wire logic [9:0] dacCode,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  wire logic wrAck = wbCyc && wbStb && wbWe && wbAck && wbSel[0];
  wire logic ctrlWr = wrAck && wbAdr == adc_seq_pkg::IDX_CONTROL_STATUS;
  wire logic pwrWr = wrAck && wbAdr == adc_seq_pkg::IDX_POWER;
  logic [11:0] sampCnt_reg;
  logic [1:0] selSeen_reg;

  // a restart clears the count, so a restarted window is not too long
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sampCnt_reg <= 12'h000;
      selSeen_reg <= 2'h0;
    end else if (ctrlWr) begin
      sampCnt_reg <= 12'h000;
      selSeen_reg <= wbDatIn[5:4];
    end else if (sampleHold) begin
      sampCnt_reg <= sampCnt_reg + 12'h001;
    end
  end

  function automatic int sampTicks(input logic [1:0] s);
    case (s)
      2'h0: return int'(adc_seq_pkg::SAMPLE_OSC_0);
      2'h1: return int'(adc_seq_pkg::SAMPLE_OSC_1);
      2'h2: return int'(adc_seq_pkg::SAMPLE_OSC_2);
      default: return int'(adc_seq_pkg::SAMPLE_OSC_3);
    endcase
  endfunction

  function automatic logic [8:0] chanHot(input logic [3:0] c);
    return (c >= 4'h1 && c <= 4'h9) ? 9'h001 << (c - 4'h1) : 9'h000;
  endfunction

  // ------------------------------------------------------------
  // sequences and properties
  // ------------------------------------------------------------
  sequence busReq;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence ctrlStart;
    ctrlWr && converterPowerOn;
  endsequence
  sequence offSteady;
    !converterPowerOn ##1 !converterPowerOn;
  endsequence

  AST_ACK_NEXT:
    assert property (busReq |=> wbAck)
      else $error("no acknowledge in the cycle after a request");
  AST_ACK_PULSE:
    assert property (wbAck |=> !wbAck)
      else $error("acknowledge longer than one cycle");
  AST_IDLE_DATA:
    assert property (!wbAck |-> wbDatOut == 32'h0000_0000)
      else $error("read data not zero outside acknowledge");
  AST_POWER_FLAG:
    assert property (pwrWr |=> converterPowerOn == $past(wbDatIn[0]))
      else $error("power flag does not follow its write");
  AST_OFF_QUIET:
    assert property (offSteady |-> !sampleHold && channelSelect == 9'h000)
      else $error("front end active while powered down");
  AST_ONE_PIN:
    assert property ($onehot0(channelSelect))
      else $error("more than one pin connected");
  AST_START:
    assert property (ctrlStart |=>
      sampleHold && channelSelect == chanHot($past(wbDatIn[3:0])))
      else $error("sampling not started on the written channel");
  AST_SAMPLE_CAUSE:
    assert property ($rose(sampleHold) |-> converterPowerOn && $past(ctrlWr))
      else $error("sampling began without a control write");
  AST_SAMPLE_LEN:
    assert property ($fell(sampleHold) && converterPowerOn |->
      sampCnt_reg >= (sampTicks(selSeen_reg) - 1) * OSC_DIV &&
      sampCnt_reg <= sampTicks(selSeen_reg) * OSC_DIV + 2)
      else $error("sampling window length wrong");
endmodule // sar_adc_sequencer_props

bind sar_adc_sequencer sar_adc_sequencer_props #(.OSC_DIV(OSC_DIV)) props_u (
  .clock(clock), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb),
  .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
  .wbDatOut(wbDatOut), .wbAck(wbAck), .sarCompare(sarCompare),
  .halfSupplyBelow(halfSupplyBelow), .converterPowerOn(converterPowerOn),
  .sampleHold(sampleHold), .channelSelect(channelSelect),
  .dacCode(dacCode), .irq(irq));

`default_nettype wire

// ===== verification/sar_adc_sequencer_bench.sv
/*
  self-checking bench for the converter sequencer over Wishbone.
  assumes the analog front end model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer_bench;
  localparam int unsigned DIV = 4;
  localparam logic [2:0] CS = adc_seq_pkg::IDX_CONTROL_STATUS;
  localparam logic [2:0] HI = adc_seq_pkg::IDX_RESULT_HIGH;
  localparam logic [2:0] PW = adc_seq_pkg::IDX_POWER;
  localparam logic [2:0] ST = adc_seq_pkg::IDX_IRQ_STATUS;
  localparam logic [2:0] MK = adc_seq_pkg::IDX_IRQ_MASK;
  logic clock, arst_n, wbCyc, wbStb, wbWe, wbAck, sarCompare, irq;
  logic halfSupplyBelow, converterPowerOn, sampleHold;
  logic [2:0] wbAdr;
  logic [3:0] wbSel, chan;
  logic [31:0] wbDatIn, wbDatOut, rd;
  logic [8:0] channelSelect;
  logic [9:0] dacCode, code;
  logic [89:0] pinLevels;
  logic [1:0] ts;
  logic [7:0] prevHigh;
  int n_fail, comparisons, cycles, waited;
  int sampTab[4] = '{20, 60, 140, 300};

  sar_adc_sequencer #(.OSC_DIV(DIV)) dut_u (
    .clock(clock), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .sarCompare(sarCompare),
    .halfSupplyBelow(halfSupplyBelow), .converterPowerOn(converterPowerOn),
    .sampleHold(sampleHold), .channelSelect(channelSelect),
    .dacCode(dacCode), .irq(irq));
  analog_front_model model_u (
    .clock(clock), .arst_n(arst_n), .pinLevels(pinLevels),
    .sampleHold(sampleHold), .channelSelect(channelSelect),
    .dacCode(dacCode), .sarCompare(sarCompare));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkRange(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] %0t wait %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // ack and read data are taken at the rising edge, before that edge's
  // nonblocking updates, so they are the values the edge samples
  task automatic busXfer(input logic [2:0] idx, input logic we,
                         input logic [7:0] d);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= idx;
    wbDatIn <= {24'h00_0000, d};
    do @(posedge clock); while (wbAck !== 1'b1);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rdChk(input logic [2:0] idx, input logic [31:0] exp);
    busXfer(idx, 1'b0, 8'h00);
    chkVal(rd, exp);
  endtask

  task automatic waitIrq(input logic lvl);
    waited = 0;
    do begin
      @(negedge clock);
      waited++;
    end while (irq !== lvl && waited < 3000);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles > 30000) begin
      n_fail++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    {wbCyc, wbStb, wbWe, halfSupplyBelow} = 4'h0;
    wbAdr = 3'h0;
    wbSel = 4'h1;
    wbDatIn = 32'h0000_0000;
    pinLevels = {10'h201, 10'h0AA, 10'h3FF, 10'h155, 10'h2AA,
                 10'h100, 10'h3FE, 10'h001, 10'h000};
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    rdChk(CS, 32'h0000_0000);
    rdChk(PW, 32'h0000_0000);
    rdChk(3'h7, 32'h0000_0000);
    busXfer(CS, 1'b1, 8'h31);
    rdChk(CS, 32'h0000_0030);
    busXfer(PW, 1'b1, 8'h01);
    waited = 0;
    do busXfer(CS, 1'b0, 8'h00); while (rd[7] !== 1'b1 && waited++ < 200);
    chkVal(rd & 32'h0000_0080, 32'h0000_0080);
    busXfer(MK, 1'b1, 8'h03);
    busXfer(ST, 1'b1, 8'h03);
    prevHigh = 8'h00;
    // channel ten is last: its result is undefined
    for (int i = 0; i < 10; i++) begin
      ts = 2'(i % 4);
      chan = (i < 9) ? 4'(i + 1) : 4'hA;
      busXfer(CS, 1'b1, {2'b00, ts, chan});
      rdChk(HI, {24'h00_0000, prevHigh});
      busXfer(CS, 1'b0, 8'h00);
      chkVal(rd & 32'h0000_0080, 32'h0000_0000);
      waitIrq(1'b1);
      chkRange(waited, (sampTab[ts] + 19) * DIV - 10,
               (sampTab[ts] + 20) * DIV + 4);
      if (i < 9) begin
        code = pinLevels[(chan - 1) * 10 +: 10];
        rdChk(CS, {24'h00_0000, 2'b10, ts, 2'b00, code[1:0]});
        rdChk(HI, {24'h00_0000, code[9:2]});
        prevHigh = code[9:2];
      end
      busXfer(ST, 1'b1, 8'h01);
      waitIrq(1'b0);
      chkRange(waited, 1, 4);
    end
    @(posedge clock);
    halfSupplyBelow <= 1'b1;
    waitIrq(1'b1);
    chkRange(waited, 1, 3 * DIV + 6);
    busXfer(CS, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_0040, 32'h0000_0040);
    busXfer(ST, 1'b1, 8'h02);
    repeat (2 * DIV) @(posedge clock);
    rdChk(ST, 32'h0000_0002);
    busXfer(MK, 1'b1, 8'h01);
    waitIrq(1'b0);
    chkRange(waited, 1, 4);
    @(posedge clock);
    halfSupplyBelow <= 1'b0;
    // a write without byte lane zero is acknowledged but ignored
    wbSel <= 4'h0;
    busXfer(MK, 1'b1, 8'h03);
    wbSel <= 4'h1;
    rdChk(MK, 32'h0000_0001);
    repeat (8) @(posedge clock);
    busXfer(ST, 1'b1, 8'h02);
    repeat (2 * DIV) @(posedge clock);
    rdChk(ST, 32'h0000_0000);
    busXfer(CS, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_0040, 32'h0000_0000);
    busXfer(PW, 1'b1, 8'h00);
    busXfer(CS, 1'b0, 8'h00);
    chkVal(rd & 32'h0000_0080, 32'h0000_0000);
    complete_run();
  end
endmodule // sar_adc_sequencer_bench

`default_nettype wire
